// [gct_global_config.sv]
// configuration registers for queues, test breakout, monitors, loop and frame length
// assumes an apb3 master on clock; port and test pins come from outside and
// are synchronised here, framer pulses and channel streams are on clock
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "gct_params.svh"

module gct_global_config (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output gct_pkg::gct_queue_t         systemVectorQueueSel,
  output gct_pkg::gct_queue_t         portVectorQueueSel,
  output logic                        testBreakoutEn,
  output gct_pkg::gct_port_t          breakoutPortSel,
  output gct_pkg::gct_ports_t         portSetupOverride,
  input  wire gct_pkg::gct_ports_t    portRxPin,
  input  wire gct_pkg::gct_ports_t    portTxCore,
  input  wire gct_pkg::gct_ports_t    portTxCoreEn,
  output gct_pkg::gct_ports_t         portTxPin,
  output gct_pkg::gct_ports_t         portTxPinOeN,
  input  wire logic                   testRxPin,
  output logic                        testTxPin,
  input  wire logic                   port0TxClockPin,
  input  wire logic                   port0Unchannelized,
  output logic                        txClockMonitorPin,
  input  wire gct_pkg::gct_ports_t    framerSyncPulse,
  output logic                        syncPulseOutPin,
  output logic                        remoteLoopEn,
  output gct_pkg::gct_chan_t          loopedChannelSel,
  input  wire logic                   rxChanValid,
  input  wire gct_pkg::gct_chan_t     rxChanId,
  input  wire logic [7:0]             rxChanByte,
  input  wire logic                   txChanReq,
  input  wire gct_pkg::gct_chan_t     txChanId,
  input  wire logic [7:0]             txChanCore,
  output logic [7:0]                  txChanByte,
  output logic                        txChanLooped,
  output gct_pkg::gct_burst_t         txFetchBurstCode,
  input  wire logic                   frameEndValid,
  input  wire logic                   smallFrameDropEn,
  input  wire logic [15:0]            frameLen,
  output gct_pkg::gct_minlen_t        minFrameBytes,
  output logic                        frameDrop
);

  // frame is too short when check is on and length does not exceed the minimum
  function automatic logic tooShort(input logic [15:0] len, input gct_pkg::gct_minlen_t minLen);
    tooShort = (minLen != 6'h00) && (len <= {10'h000, minLen});
  endfunction

  // a port or framer number is legal only up to the last port
  function automatic logic inRange(input gct_pkg::gct_port_t idx);
    inRange = (idx <= `GCT_LAST_PORT);
  endfunction

  logic [31:0]         queueLoop_q;
  logic [31:0]         burstMin_q;
  logic [31:0]         prdata_q;
  gct_pkg::gct_ports_t rxMeta_q;
  gct_pkg::gct_ports_t rxSync_q;
  logic                testMeta_q;
  logic                testSync_q;
  logic                clkMeta_q;
  logic                clkSync_q;
  gct_pkg::gct_ports_t portTx_q;
  gct_pkg::gct_ports_t portOeN_q;
  logic                testTx_q;
  logic                clkMon_q;
  logic                syncMon_q;
  logic [7:0]          loopByte_q;
  logic [7:0]          txByte_q;
  logic                txLooped_q;
  logic                frameDrop_q;

  wire                 setupPhase;
  wire                 accessPhase;
  wire                 hitQueueLoop;
  wire                 hitBurstMin;
  wire                 mapped;
  wire                 wrQueueLoop;
  wire                 wrBurstMin;
  wire [31:0]          readMux;
  wire                 breakout;
  wire                 monitorOn;
  gct_pkg::gct_port_t  bPort;
  gct_pkg::gct_port_t  framerSel;
  gct_pkg::gct_chan_t  loopChan;
  gct_pkg::gct_ports_t bSelect;
  gct_pkg::gct_ports_t portTx_d;
  gct_pkg::gct_ports_t portOeN_d;
  wire                 testTx_d;
  wire                 clkMon_d;
  wire                 syncMon_d;
  wire                 loopCapture;
  wire                 txLoopHit;

  // apb decode; the slave never stalls, so pready is tied high in the access phase
  assign setupPhase   = psel && !penable;
  assign accessPhase  = psel && penable;
  assign hitQueueLoop = (paddr == `GCT_OFF_QUEUE_LOOP);
  assign hitBurstMin  = (paddr == `GCT_OFF_BURST_MIN);
  assign mapped       = hitQueueLoop || hitBurstMin;
  assign wrQueueLoop  = ce && accessPhase && pwrite && hitQueueLoop;
  assign wrBurstMin   = ce && accessPhase && pwrite && hitBurstMin;
  assign readMux      = hitQueueLoop ? queueLoop_q :
                        hitBurstMin  ? burstMin_q  : 32'h0000_0000;
  assign pready       = 1'b1;
  assign pslverr      = accessPhase && !mapped;
  assign prdata       = prdata_q;

  // field views of the stored words
  assign systemVectorQueueSel = queueLoop_q[`GCT_SYS_QUEUE_HI:`GCT_SYS_QUEUE_LO];
  assign portVectorQueueSel   = queueLoop_q[`GCT_PORT_QUEUE_HI:`GCT_PORT_QUEUE_LO];
  assign breakout             = queueLoop_q[`GCT_BREAKOUT];
  assign bPort                = queueLoop_q[`GCT_BPORT_HI:`GCT_BPORT_LO];
  assign framerSel            = queueLoop_q[`GCT_FRAMER_HI:`GCT_FRAMER_LO];
  assign loopChan             = queueLoop_q[`GCT_LCHAN_HI:`GCT_LCHAN_LO];
  assign testBreakoutEn       = breakout;
  assign breakoutPortSel      = bPort;
  assign remoteLoopEn         = queueLoop_q[`GCT_LOOP_EN];
  assign loopedChannelSel     = loopChan;
  assign txFetchBurstCode     = burstMin_q[`GCT_BURST_HI:`GCT_BURST_LO];
  assign minFrameBytes        = burstMin_q[`GCT_MIN_LEN_HI:`GCT_MIN_LEN_LO];

  // breakout wins over the sync monitor enable
  assign monitorOn = queueLoop_q[`GCT_MONITOR] && !breakout;

  // one-hot of the port switched to the test pins; an out-of-range number picks none
  genvar gp;
  generate
    for (gp = 0; gp < `GCT_NUM_PORTS; gp = gp + 1) begin : g_port
      assign bSelect[gp] = breakout && (bPort == 5'(gp));
      assign portTx_d[gp] = bSelect[gp] ? testSync_q : portTxCore[gp];
      // the selected port drives regardless of its own enable
      assign portOeN_d[gp] = !(bSelect[gp] || portTxCoreEn[gp]);
    end
  endgenerate

  assign portSetupOverride = bSelect;
  assign testTx_d  = (breakout && inRange(bPort)) ? rxSync_q[bPort] : 1'b0;

  // the clock is resampled at 100 MHz, so only slow clocks show faithfully
  assign clkMon_d  = !queueLoop_q[`GCT_MONITOR] && port0Unchannelized
                     && clkSync_q;
  assign syncMon_d = monitorOn && inRange(framerSel)
                     && framerSyncPulse[framerSel];

  // a single-entry loop buffer is enough since only one channel loops
  assign loopCapture = remoteLoopEn && rxChanValid && (rxChanId == loopChan);
  assign txLoopHit   = remoteLoopEn && txChanReq && (txChanId == loopChan);

  assign portTxPin         = portTx_q;
  assign portTxPinOeN      = portOeN_q;
  assign testTxPin         = testTx_q;
  assign txClockMonitorPin = clkMon_q;
  assign syncPulseOutPin   = syncMon_q;
  assign txChanByte        = txByte_q;
  assign txChanLooped      = txLooped_q;
  assign frameDrop         = frameDrop_q;

  // register file; fixed-zero positions are masked off on write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      queueLoop_q <= `GCT_RST_QUEUE_LOOP;
    end else if (wrQueueLoop) begin
      queueLoop_q <= pwdata & `GCT_MASK_QUEUE_LOOP;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      burstMin_q <= `GCT_RST_BURST_MIN;
    end else if (wrBurstMin) begin
      burstMin_q <= pwdata & `GCT_MASK_BURST_MIN;
    end
  end

  // read data is latched in the setup phase and stands through the access phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce && setupPhase) begin
      prdata_q <= pwrite ? 32'h0000_0000 : readMux;
    end
  end

  // two-flop synchronisers for everything arriving on pins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxMeta_q <= 28'h000_0000;
      rxSync_q <= 28'h000_0000;
    end else if (ce) begin
      rxMeta_q <= portRxPin;
      rxSync_q <= rxMeta_q;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      testMeta_q <= 1'b0;
      testSync_q <= 1'b0;
    end else if (ce) begin
      testMeta_q <= testRxPin;
      testSync_q <= testMeta_q;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clkMeta_q <= 1'b0;
      clkSync_q <= 1'b0;
    end else if (ce) begin
      clkMeta_q <= port0TxClockPin;
      clkSync_q <= clkMeta_q;
    end
  end

  // pin outputs; ports stay tri-stated after reset until enabled
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      portTx_q <= 28'h000_0000;
    end else if (ce) begin
      portTx_q <= portTx_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      portOeN_q <= 28'hFFF_FFFF;
    end else if (ce) begin
      portOeN_q <= portOeN_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      testTx_q <= 1'b0;
    end else if (ce) begin
      testTx_q <= testTx_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clkMon_q <= 1'b0;
    end else if (ce) begin
      clkMon_q <= clkMon_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      syncMon_q <= 1'b0;
    end else if (ce) begin
      syncMon_q <= syncMon_d;
    end
  end

  // remote channel loop buffer and transmit substitution
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loopByte_q <= 8'h00;
    end else if (ce && loopCapture) begin
      loopByte_q <= rxChanByte;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txByte_q <= 8'h00;
    end else if (ce && txChanReq) begin
      txByte_q <= txLoopHit ? loopByte_q : txChanCore;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txLooped_q <= 1'b0;
    end else if (ce) begin
      txLooped_q <= txLoopHit;
    end
  end

  // small-frame drop decision, one pulse per dropped frame
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frameDrop_q <= 1'b0;
    end else if (ce) begin
      frameDrop_q <= frameEndValid && smallFrameDropEn
                     && tooShort(frameLen, minFrameBytes);
    end
  end

endmodule

`default_nettype wire

// [gct_global_config_assertions.sv]
// port-level assertions for the configuration register bank
// assumes binding into gct_global_config, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none

module gct_global_config_assertions (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire logic                 ce,
  input wire logic [11:0]          paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire gct_pkg::gct_queue_t  systemVectorQueueSel,
  input wire gct_pkg::gct_queue_t  portVectorQueueSel,
  input wire logic                 testBreakoutEn,
  input wire gct_pkg::gct_port_t   breakoutPortSel,
  input wire gct_pkg::gct_ports_t  portSetupOverride,
  input wire logic                 syncPulseOutPin,
  input wire logic                 remoteLoopEn,
  input wire logic                 txChanReq,
  input wire logic [7:0]           txChanCore,
  input wire logic [7:0]           txChanByte,
  input wire logic                 txChanLooped,
  input wire gct_pkg::gct_burst_t  txFetchBurstCode,
  input wire logic                 frameEndValid,
  input wire logic                 smallFrameDropEn,
  input wire logic [15:0]          frameLen,
  input wire gct_pkg::gct_minlen_t minFrameBytes,
  input wire logic                 frameDrop
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic acc = psel && penable && ce;
  wire logic wrQ = acc && pwrite && paddr == 12'h044;
  wire logic wrB = acc && pwrite && paddr == 12'h048;
  wire logic shortFrame = smallFrameDropEn && minFrameBytes != 6'h0
                          && frameLen <= {10'h000, minFrameBytes};
  chk_system_queue: assert property (wrQ
    |=> systemVectorQueueSel == $past(pwdata[30:28])) else $error("system queue field wrong");
  chk_port_queue: assert property (wrQ |=> portVectorQueueSel == $past(pwdata[26:24]))
    else $error("port queue field wrong");
  chk_burst_write: assert property (wrB |=> txFetchBurstCode == $past(pwdata[19:16]))
    else $error("burst code field wrong");
  chk_zero_bits_q: assert property ($past(ce) && acc && !pwrite && paddr == 12'h044
    |-> (prdata & 32'h8820_6000) == 32'h0) else $error("fixed bits read nonzero");
  chk_zero_bits_b: assert property ($past(ce) && acc && !pwrite && paddr == 12'h048
    |-> (prdata & 32'hFFF0_C0FF) == 32'h0) else $error("fixed bits read nonzero");
  chk_breakout_onehot: assert property (portSetupOverride ==
    (testBreakoutEn ? (28'h000_0001 << breakoutPortSel) : 28'h000_0000))
    else $error("port override not one-hot on selected port");
  chk_breakout_mutes: assert property ($past(ce) && $past(testBreakoutEn)
    |-> !syncPulseOutPin) else $error("sync pulse shown during breakout");
  chk_loop_off: assert property (txChanReq && ce && !remoteLoopEn
    |=> !txChanLooped && txChanByte == $past(txChanCore)) else $error("byte looped while off");
  chk_frame_drop: assert property (frameEndValid && ce
    |=> frameDrop == $past(shortFrame)) else $error("frame drop decision wrong");
endmodule

bind gct_global_config gct_global_config_assertions i_chk (.*);

`default_nettype wire

// [gct_params.svh]
// constants of the global configuration / test loop register bank
// assumes a 32-bit apb slave with word-aligned byte addresses
// Summary of operation
// - bits 30:28 pick the queue that takes all system interrupt vectors.
// - bits 26:24 pick the queue that takes all port interrupt vectors.
// - breakout bit 23 swaps the chosen port's pins onto the test pins.
// - breakout releases port tri-state, overrides port setup and sync monitor.
// - monitor enable low shows port zero's transmit clock if unchannelized.
// - monitor enable high drives the chosen framer's sync pulse to its pin.
// - five-bit field 20:16 picks framer 0..27, only while monitoring.
// - remote loop bit 15 loops one channel's receive data into its transmit.
// - five-bit field 12:8 picks the port switched to the test pins.
// - eight-bit field 7:0 picks the channel for the remote loop.
// - bits 19:16 of the second register hold the burst code, reset 00090000.
// - enabled channels drop frames whose length is at most the minimum.
// - a minimum length of zero turns the small-frame check off.
`ifndef GCT_PARAMS_SVH
`define GCT_PARAMS_SVH

`define GCT_ADDR_W          12
`define GCT_OFF_QUEUE_LOOP  12'h044
`define GCT_OFF_BURST_MIN   12'h048
`define GCT_RST_QUEUE_LOOP  32'h0000_0000
`define GCT_RST_BURST_MIN   32'h0009_0000
`define GCT_MASK_QUEUE_LOOP 32'h77DF_9FFF
`define GCT_MASK_BURST_MIN  32'h000F_3F00

`define GCT_SYS_QUEUE_HI  30
`define GCT_SYS_QUEUE_LO  28
`define GCT_PORT_QUEUE_HI 26
`define GCT_PORT_QUEUE_LO 24
`define GCT_BREAKOUT    23
`define GCT_MONITOR     22
`define GCT_FRAMER_HI   20
`define GCT_FRAMER_LO   16
`define GCT_LOOP_EN     15
`define GCT_BPORT_HI    12
`define GCT_BPORT_LO    8
`define GCT_LCHAN_HI    7
`define GCT_LCHAN_LO    0
`define GCT_BURST_HI    19
`define GCT_BURST_LO    16
`define GCT_MIN_LEN_HI  13
`define GCT_MIN_LEN_LO  8

`define GCT_NUM_PORTS   28
`define GCT_LAST_PORT   5'h1B

`endif

// [gct_pkg.sv]
// types shared by the global configuration / test loop register bank
// assumes gct_params.svh for all numeric constants
package gct_pkg;
  typedef logic [2:0]  gct_queue_t;
  typedef logic [4:0]  gct_port_t;
  typedef logic [7:0]  gct_chan_t;
  typedef logic [3:0]  gct_burst_t;
  typedef logic [5:0]  gct_minlen_t;
  typedef logic [27:0] gct_ports_t;
endpackage

// [gct_testbench.sv]
// self-checking bench for the configuration register bank
// assumes the design and checker files are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                 clock, sys_rst, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata;
  gct_pkg::gct_queue_t  systemVectorQueueSel, portVectorQueueSel;
  logic                 testBreakoutEn, testRxPin, testTxPin, port0TxClockPin;
  logic                 port0Unchannelized, txClockMonitorPin, syncPulseOutPin, remoteLoopEn;
  logic                 rxChanValid, txChanReq, txChanLooped, frameEndValid;
  logic                 smallFrameDropEn, frameDrop;
  gct_pkg::gct_port_t   breakoutPortSel;
  gct_pkg::gct_ports_t  portSetupOverride, portRxPin, portTxCore, portTxCoreEn;
  gct_pkg::gct_ports_t  portTxPin, portTxPinOeN, framerSyncPulse;
  gct_pkg::gct_chan_t   loopedChannelSel, rxChanId, txChanId;
  logic [7:0]           rxChanByte, txChanCore, txChanByte;
  gct_pkg::gct_burst_t  txFetchBurstCode;
  gct_pkg::gct_minlen_t minFrameBytes;
  logic [15:0]          frameLen;
  int                   mismatches, compares, cycles;

  gct_global_config i_dut (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic final_report;
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard: the full sequence needs about a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] x, input logic e);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    if (!w) chk(prdata, x);
    chk(32'(pslverr), 32'(e));
    {psel, penable} <= 2'b00;
  endtask

  task automatic t_regs;
    @(negedge clock);
    chk(32'(txFetchBurstCode), 32'h9);
    apb(12'h044, 1'b0, 32'h0, 32'h0000_0000, 1'b0);
    apb(12'h048, 1'b0, 32'h0, 32'h0009_0000, 1'b0);
    apb(12'h044, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(12'h044, 1'b0, 32'h0, 32'h77DF_9FFF, 1'b0);
    apb(12'h048, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(12'h048, 1'b0, 32'h0, 32'h000F_3F00, 1'b0);
    apb(12'h04C, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b1);
    apb(12'h04C, 1'b0, 32'h0, 32'h0, 1'b1);
    @(negedge clock);
    chk(32'(txFetchBurstCode), 32'hF);
    chk(32'(minFrameBytes), 32'h3F);
    apb(12'h044, 1'b1, 32'h2500_0000, 32'h0, 1'b0);
    @(negedge clock);
    chk(32'(systemVectorQueueSel), 32'h2);
    chk(32'(portVectorQueueSel), 32'h5);
  endtask

  task automatic t_pins;
    apb(12'h044, 1'b1, 32'h00C3_0500, 32'h0, 1'b0);
    @(posedge clock);
    {testRxPin, portRxPin, framerSyncPulse, portTxCore} <=
      {1'b1, 28'h000_0020, 28'hFFF_FFFF, 28'h000_0010};
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk(32'(portTxPin[5]), 32'h1);
    chk(32'(portTxPin[4]), 32'h1);
    chk(32'(testTxPin), 32'h1);
    chk(32'(portTxPinOeN[5]), 32'h0);
    chk(32'(portSetupOverride), 32'h0000_0020);
    chk(32'(syncPulseOutPin), 32'h0);
    apb(12'h044, 1'b1, 32'h0043_0500, 32'h0, 1'b0);
    @(posedge clock);
    framerSyncPulse <= 28'h000_0008;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(32'(syncPulseOutPin), 32'h1);
    chk(32'(portTxPinOeN[5]), 32'h1);
    apb(12'h044, 1'b1, 32'h005B_0000, 32'h0, 1'b0);
    @(posedge clock);
    framerSyncPulse <= 28'h7FF_FFFF;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(32'(syncPulseOutPin), 32'h0);
    apb(12'h044, 1'b1, 32'h0, 32'h0, 1'b0);
    @(posedge clock);
    {port0Unchannelized, port0TxClockPin} <= 2'b11;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk(32'(txClockMonitorPin), 32'h1);
    @(posedge clock);
    port0Unchannelized <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(32'(txClockMonitorPin), 32'h0);
  endtask

  task automatic tx(input logic [7:0] id, input logic [7:0] b, input logic l);
    @(posedge clock);
    {rxChanValid, txChanReq, txChanId, txChanCore} <= {2'b01, id, 8'h3C};
    @(posedge clock);
    txChanReq <= 1'b0;
    @(negedge clock);
    chk(32'(txChanByte), 32'(b));
    chk(32'(txChanLooped), 32'(l));
  endtask

  task automatic t_loop;
    apb(12'h044, 1'b1, 32'h0000_802A, 32'h0, 1'b0);
    @(posedge clock);
    {rxChanValid, rxChanId, rxChanByte} <= {1'b1, 8'h2A, 8'hA5};
    chk(32'(remoteLoopEn), 32'h1);
    chk(32'(loopedChannelSel), 32'h2A);
    tx(8'h2A, 8'hA5, 1'b1);
    tx(8'h2B, 8'h3C, 1'b0);
    apb(12'h044, 1'b1, 32'h0000_002A, 32'h0, 1'b0);
    tx(8'h2A, 8'h3C, 1'b0);
  endtask

  task automatic fr(input logic [15:0] len, input logic e, input logic x);
    @(posedge clock);
    {frameEndValid, frameLen, smallFrameDropEn} <= {1'b1, len, e};
    @(posedge clock);
    frameEndValid <= 1'b0;
    @(negedge clock);
    chk(32'(frameDrop), 32'(x));
  endtask

  task automatic t_frame;
    apb(12'h048, 1'b1, 32'h0009_0400, 32'h0, 1'b0);
    fr(16'h0003, 1'b1, 1'b1);
    fr(16'h0004, 1'b1, 1'b1);
    fr(16'h0005, 1'b1, 1'b0);
    fr(16'h0004, 1'b0, 1'b0);
    apb(12'h048, 1'b1, 32'h0009_0000, 32'h0, 1'b0);
    fr(16'h0001, 1'b1, 1'b0);
  endtask

  initial begin
    {psel, penable, pwrite, rxChanValid, txChanReq, frameEndValid} = '0;
    {paddr, pwdata, frameLen, portRxPin, portTxCore, portTxCoreEn, framerSyncPulse} = '0;
    {testRxPin, port0TxClockPin, port0Unchannelized, smallFrameDropEn} = '0;
    {rxChanId, rxChanByte, txChanId, txChanCore} = '0;
    {sys_rst, ce} = 2'b11;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs;
    t_pins;
    t_loop;
    t_frame;
    final_report;
  end
endmodule

`default_nettype wire
